// File: dv/rotate_right_byte_unit_test.sv
// Self-checking testbench for the rotate right byte unit
`timescale 1ns/1ps
module rotate_right_byte_unit_test;
  // ****************************************
  // Signals and unit
  // ****************************************
  logic clock, resetn, extended_en, mem_rd, mem_wr, neg_r, zero_r, carry_r;
  logic done;
  logic [15:0] instr;
  logic [3:0] bank_select_register;
  logic [7:0] index_base, mem_rdata, mem_wdata, working_r;
  logic [11:0] mem_addr;
  logic [1:0] phase;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;

  rotate_right_byte_unit uut (.clock(clock), .resetn(resetn), .instr(instr),
    .extended_en(extended_en), .bank_select_register(bank_select_register),
    .index_base(index_base), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .working_r(working_r), .neg_r(neg_r), .zero_r(zero_r),
    .carry_r(carry_r), .phase(phase), .done(done));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 400) begin
      fail_count++;
      test_done();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One instruction cycle, entered at a falling edge in phase 0
  task automatic op(input logic [15:0] ins, input logic [11:0] addr,
                    input logic [7:0] src, input logic rd, input logic wr,
                    input logic [7:0] res);
    instr = ins;
    @(posedge clock);
    @(negedge clock);
    check(phase, 2'h1);
    check(mem_rd, rd);
    if (rd) check(mem_addr, addr);
    mem_rdata = src;
    @(posedge clock);
    @(negedge clock);
    mem_rdata = ~src;
    @(posedge clock);
    @(negedge clock);
    check(done, 1'b1);
    check(mem_wr, wr);
    if (rd) check(mem_wdata, res);
    @(posedge clock);
    @(negedge clock);
  endtask : op

  task automatic flags(input logic n, input logic z, input logic c);
    check(neg_r, n);
    check(zero_r, z);
    check(carry_r, c);
  endtask : flags

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_carry();
    op(16'h3010, 12'h010, 8'h01, 1'b1, 1'b0, 8'h00);
    flags(1'b0, 1'b1, 1'b1);
  endtask : t_carry

  task automatic t_wrap();
    bank_select_register = 4'h5;
    op(16'h4381, 12'h581, 8'h01, 1'b1, 1'b1, 8'h80);
    flags(1'b1, 1'b0, 1'b1);
  endtask : t_wrap

  task automatic t_work();
    op(16'h40c0, 12'h0c0, 8'ha4, 1'b1, 1'b0, 8'h52);
    check(working_r, 8'h52);
    flags(1'b0, 1'b0, 1'b1);
    op(16'h40c0, 12'h0c0, 8'h00, 1'b1, 1'b0, 8'h00);
    check(working_r, 8'h00);
    flags(1'b0, 1'b1, 1'b1);
  endtask : t_work

  task automatic t_index();
    extended_en = 1'b1;
    index_base = 8'h20;
    op(16'h425f, 12'h07f, 8'h02, 1'b1, 1'b1, 8'h01);
    op(16'h4260, 12'h060, 8'h02, 1'b1, 1'b1, 8'h01);
    extended_en = 1'b0;
  endtask : t_index

  task automatic t_refuse();
    op(16'h2400, 12'h000, 8'hff, 1'b0, 1'b0, 8'h00);
    flags(1'b0, 1'b0, 1'b1);
    check(working_r, 8'h00);
  endtask : t_refuse

  // ****************************************
  // Closing report
  // ****************************************
  task automatic test_done();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  initial begin
    resetn = 1'b0;
    instr = 16'h0000;
    extended_en = 1'b0;
    bank_select_register = 4'h0;
    index_base = 8'h00;
    mem_rdata = 8'h00;
    repeat (3) @(negedge clock);
    resetn = 1'b1;
    t_carry();
    t_wrap();
    t_work();
    t_index();
    t_refuse();
    test_done();
  end
endmodule : rotate_right_byte_unit_test

// File: rtl/file_port.sv
// Pass-through from the rotate_if mem modport to the data memory pins
`timescale 1ns/1ps
module file_port (
  rotate_if.mem bus,
  input wire logic [7:0] mem_rdata,
  output logic [11:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata
);
  assign mem_addr = bus.addr;
  assign mem_rd = bus.rd;
  assign mem_wr = bus.wr;
  assign mem_wdata = bus.wdata;
  assign bus.rdata = mem_rdata;
endmodule : file_port

// File: rtl/rotate_if.sv
// Interface carrying the data memory access between core and file port
`timescale 1ns/1ps
interface rotate_if;
  logic [11:0] addr;
  logic rd;
  logic wr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport core (output addr, output rd, output wr, output wdata,
                input rdata);
  modport mem (input addr, input rd, input wr, input wdata,
               output rdata);
endinterface : rotate_if

// File: rtl/rotate_pkg.sv
// Package with constants for the rotate right byte unit
package rotate_pkg;
  // ****************************************
  // Opcode fields, address limits and phase constants
  // ****************************************
  localparam logic [5:0] opc_rotate_right_no_carry = 6'h10;
  localparam logic [5:0] opc_rotate_right_through_carry = 6'h0c;
  localparam int opc_hi = 15;
  localparam int opc_lo = 10;
  localparam int dest_bit = 9;
  localparam int access_bit = 8;
  localparam logic [7:0] indexed_limit = 8'h5f;
  localparam logic [3:0] access_bank = 4'h0;
  localparam logic [7:0] reset_byte = 8'h00;
  localparam int phases = 4;
  typedef enum logic [1:0] {ph_decode, ph_read, ph_process, ph_write} phase_t;
endpackage : rotate_pkg

// File: rtl/rotate_right_byte_unit.sv
// Execution datapath for the byte rotate right instructions
//
// Contract
// - Source bit n goes to bit n-1
// - Source bit 0 wraps into bit 7 for no carry; through carry, old carry goes to bit 7
// - Negative and zero flags change; carry changes only for rotate through carry
// - Operands: 8-bit address, dest and access bits
// - One instruction cycle in four phases
// - Source read happens in second phase
// - Indexed offset when access 0, extended, f<=95
// - Dest 0 to working register, 1 to f
// - Access 0 access bank, 1 uses bank select
// - Decode opcodes 0100 00da ffff ffff (no carry) and 0011 00da ffff ffff (through carry)
`timescale 1ns/1ps
module rotate_right_byte_unit (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [15:0] instr,
  input wire logic extended_en,
  input wire logic [3:0] bank_select_register,
  input wire logic [7:0] index_base,
  input wire logic [7:0] mem_rdata,
  output logic [11:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  output logic [7:0] working_r,
  output logic neg_r,
  output logic zero_r,
  output logic carry_r,
  output logic [1:0] phase,
  output logic done
);
  // ****************************************
  // Phase counter
  // ****************************************
  rotate_pkg::phase_t phase_r;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      phase_r <= rotate_pkg::ph_decode;
    end else begin
      case (phase_r)
        rotate_pkg::ph_decode: phase_r <= rotate_pkg::ph_read;
        rotate_pkg::ph_read: phase_r <= rotate_pkg::ph_process;
        rotate_pkg::ph_process: phase_r <= rotate_pkg::ph_write;
        rotate_pkg::ph_write: phase_r <= rotate_pkg::ph_decode;
        default: phase_r <= rotate_pkg::ph_decode;
      endcase
    end
  end
  assign phase = phase_r;
  assign done = (phase_r == rotate_pkg::ph_write);

  // ****************************************
  // Decode
  // ****************************************
  logic [15:0] instr_r;
  logic is_rrn_r;
  logic is_rrc_r;
  logic [11:0] addr_r;
  logic [11:0] addr_nxt;
  logic [7:0] faddr;
  logic acc;
  assign faddr = instr[7:0];
  assign acc = instr[rotate_pkg::access_bit];
  always_comb begin
    if (!acc && extended_en && faddr <= rotate_pkg::indexed_limit) begin
      addr_nxt = {4'h0, index_base + faddr};
    end else if (!acc) begin
      addr_nxt = {rotate_pkg::access_bank, faddr};
    end else begin
      addr_nxt = {bank_select_register, faddr};
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      instr_r <= 16'h0000;
      is_rrn_r <= 1'b0;
      is_rrc_r <= 1'b0;
      addr_r <= 12'h000;
    end else if (phase_r == rotate_pkg::ph_decode) begin
      instr_r <= instr;
      is_rrn_r <= instr[rotate_pkg::opc_hi:rotate_pkg::opc_lo] ==
                  rotate_pkg::opc_rotate_right_no_carry;
      is_rrc_r <= instr[rotate_pkg::opc_hi:rotate_pkg::opc_lo] ==
                  rotate_pkg::opc_rotate_right_through_carry;
      addr_r <= addr_nxt;
    end
  end

  // ****************************************
  // Read and process
  // ****************************************
  logic [7:0] src_r;
  logic [7:0] res_r;
  logic [7:0] res_nxt;
  logic active;
  assign active = is_rrn_r || is_rrc_r;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      src_r <= rotate_pkg::reset_byte;
    end else if (phase_r == rotate_pkg::ph_read) begin
      src_r <= bus.rdata;
    end
  end
  always_comb begin
    if (is_rrn_r) begin
      res_nxt = {src_r[0], src_r[7:1]};
    end else begin
      res_nxt = {carry_r, src_r[7:1]};
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      res_r <= rotate_pkg::reset_byte;
    end else if (phase_r == rotate_pkg::ph_process) begin
      res_r <= res_nxt;
    end
  end

  // ****************************************
  // Write and flags
  // ****************************************
  logic dest;
  assign dest = instr_r[rotate_pkg::dest_bit];
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      working_r <= rotate_pkg::reset_byte;
    end else if (done && active && !dest) begin
      working_r <= res_r;
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      neg_r <= 1'b0;
      zero_r <= 1'b0;
    end else if (done && active) begin
      neg_r <= res_r[7];
      zero_r <= (res_r == 8'h00);
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      carry_r <= 1'b0;
    end else if (done && is_rrc_r) begin
      carry_r <= src_r[0];
    end
  end

  // ****************************************
  // Memory port
  // ****************************************
  rotate_if bus ();
  assign bus.addr = addr_r;
  assign bus.rd = active && (phase_r == rotate_pkg::ph_read);
  assign bus.wr = active && done && dest;
  assign bus.wdata = res_r;
  file_port port_i (
    .bus(bus.mem),
    .mem_rdata(mem_rdata),
    .mem_addr(mem_addr),
    .mem_rd(mem_rd),
    .mem_wr(mem_wr),
    .mem_wdata(mem_wdata)
  );

  // ****************************************
  // Checks
  // ****************************************
  sequence read_phase_s;
    phase_r == rotate_pkg::ph_read;
  endsequence
  sequence write_phase_s;
    ##2 done;
  endsequence
  rotate_wrap_a: assert property (@(posedge clock)
    disable iff (!resetn)
    done && is_rrn_r |-> res_r == {src_r[0], src_r[7:1]})
    else $error("rotate result wrong");
  shift_bits_a: assert property (@(posedge clock)
    disable iff (!resetn)
    done && is_rrn_r |-> res_r[6:0] == src_r[7:1])
    else $error("shift bits wrong");
  carry_hold_a: assert property (@(posedge clock)
    disable iff (!resetn)
    done && is_rrn_r |=> $stable(carry_r))
    else $error("carry changed");
  cycle_len_a: assert property (@(posedge clock)
    disable iff (!resetn)
    done |=> !done [*3] ##1 done)
    else $error("cycle not four phases");
  phase_walk_a: assert property (@(posedge clock)
    disable iff (!resetn)
    phase_r == rotate_pkg::ph_decode |=> phase_r == rotate_pkg::ph_read)
    else $error("decode not followed by read");
  read_order_a: assert property (@(posedge clock)
    disable iff (!resetn)
    mem_rd |-> read_phase_s ##0 write_phase_s)
    else $error("read out of order");
  read_src_a: assert property (@(posedge clock)
    disable iff (!resetn)
    phase_r == rotate_pkg::ph_process |-> src_r == $past(mem_rdata))
    else $error("source not taken in read phase");
  dest_w_a: assert property (@(posedge clock)
    disable iff (!resetn)
    done && active && !dest |=> working_r == $past(res_r) &&
    !$past(mem_wr))
    else $error("working write wrong");
  bank_sel_a: assert property (@(posedge clock)
    disable iff (!resetn)
    phase_r == rotate_pkg::ph_decode && acc |=>
    addr_r[11:8] == $past(bank_select_register))
    else $error("bank select wrong");
  access_bank_a: assert property (@(posedge clock)
    disable iff (!resetn)
    phase_r == rotate_pkg::ph_decode && !acc &&
    !(extended_en && faddr <= rotate_pkg::indexed_limit) |=>
    addr_r == {rotate_pkg::access_bank, $past(faddr)})
    else $error("access bank address wrong");
  index_addr_a: assert property (@(posedge clock)
    disable iff (!resetn)
    phase_r == rotate_pkg::ph_decode && !acc && extended_en &&
    faddr <= rotate_pkg::indexed_limit |=>
    addr_r == {4'h0, 8'($past(index_base) + $past(faddr))})
    else $error("indexed address wrong");
  flag_update_a: assert property (@(posedge clock)
    disable iff (!resetn)
    done && active |=> zero_r == ($past(res_r) == 8'h00) &&
    neg_r == $past(res_r[7]))
    else $error("flags wrong");
  rotate_decode_a: assert property (@(posedge clock)
    disable iff (!resetn)
    phase_r == rotate_pkg::ph_decode &&
    instr[15:10] == rotate_pkg::opc_rotate_right_no_carry |=> is_rrn_r)
    else $error("decode missed");
  refuse_hold_a: assert property (@(posedge clock)
    disable iff (!resetn)
    done && !active |=> $stable(neg_r) && $stable(zero_r) &&
    $stable(working_r) && $stable(carry_r))
    else $error("other opcode changed state");
endmodule : rotate_right_byte_unit
